// *** src/stpg_port_gate.sv ***
// Per-port spanning tree state machine and traffic gate
`timescale 1ns/1ps
module stpg_port_gate
    import stpg_pkg::*;
#(
    parameter longint unsigned FWD_DELAY_CYC = STPG_FWD_DELAY_CYC,
    parameter longint unsigned MAX_AGE_CYC   = STPG_MAX_AGE_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic stp_enable,
    input  wire logic port_enable,
    input  wire logic bpdu_exchange,
    input  wire logic superior_bpdu,
    input  wire logic go_blocking,
    input  wire logic go_forward,
    input  wire logic rx_frame_valid,
    input  wire logic rx_frame_is_bpdu,
    input  wire logic rx_frame_is_mgmt,
    input  wire logic fab_frame_valid,
    input  wire logic cpu_bpdu_valid,
    output logic      cpu_bpdu_ready,
    output logic      rx_fwd,
    output logic      rx_drop,
    output logic      fab_tx,
    output logic      fab_drop,
    output logic      learn_en,
    output logic      bpdu_to_cpu,
    output logic      mgmt_to_cpu,
    output logic      bpdu_tx,
    output logic      bpdu_consume,
    output logic [2:0] port_state
);

    stpg_state_type state_reg;
    stpg_state_type state_next;
    logic           fd_load;
    logic           fd_clear;
    logic           fd_expired;
    logic           ma_load;
    logic           ma_expired;
    logic           ma_running_reg;
    logic           ma_running_next;
    logic           rx_fwd_next;
    logic           rx_drop_next;
    logic           fab_tx_next;
    logic           fab_drop_next;
    logic           bpdu_cpu_next;
    logic           mgmt_cpu_next;
    logic           bpdu_tx_next;
    logic           bpdu_cons_next;
    logic           rx_fwd_reg;
    logic           rx_drop_reg;
    logic           fab_tx_reg;
    logic           fab_drop_reg;
    logic           bpdu_cpu_reg;
    logic           mgmt_cpu_reg;
    logic           bpdu_tx_reg;
    logic           bpdu_cons_reg;
    logic           cpu_take;
    logic           rx_data;
    logic           fd_busy;
    logic           fd_busy_reg;
    logic           fd_busy_next;

    // Forward delay timer
    stpg_timer #(.W(STPG_TMR_W)) u_fwd_timer (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .load     (fd_load),
        .clear    (fd_clear),
        .load_val (STPG_TMR_W'(FWD_DELAY_CYC)),
        .expired  (fd_expired)
    );

    // Max age timer, restarted by each superior BPDU received while blocking
    stpg_timer #(.W(STPG_TMR_W)) u_age_timer (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .load     (ma_load),
        .clear    (1'b0),
        .load_val (STPG_TMR_W'(MAX_AGE_CYC)),
        .expired  (ma_expired)
    );

    always_comb begin
        state_next      = state_reg;
        fd_load         = 1'b0;
        fd_clear        = 1'b0;
        ma_running_next = ma_running_reg;
        ma_load         = 1'b0;
        if (!port_enable || !stp_enable) begin
            if (!port_enable) begin
                state_next = STPG_DISABLED;
            end else begin
                state_next = STPG_FORWARDING;
            end
            fd_clear = 1'b1;
            // A stale max age watch would keep a re-enabled port blocked for good
            ma_running_next = 1'b0;
        end else begin
            unique case (state_reg)
                STPG_BLOCKING: begin
                    // Superior BPDUs keep the port blocked and restart max age
                    if (superior_bpdu) begin
                        ma_load         = 1'b1;
                        ma_running_next = 1'b1;
                        fd_clear        = 1'b1;
                    end else if (go_forward || (ma_running_reg && ma_expired)) begin
                        state_next      = STPG_LISTENING;
                        ma_running_next = 1'b0;
                        fd_load         = 1'b1;
                    end else if (!bpdu_exchange && !ma_running_reg && fd_expired) begin
                        state_next = STPG_LISTENING;
                        fd_load    = 1'b1;
                    end else if (!bpdu_exchange && !ma_running_reg && !fd_expired) begin
                        fd_load = 1'b0;
                    end
                end
                STPG_LISTENING: begin
                    if (go_blocking) begin
                        state_next = STPG_BLOCKING;
                        fd_clear   = 1'b1;
                    end else if (fd_expired) begin
                        state_next = STPG_LEARNING;
                        fd_load    = 1'b1;
                    end
                end
                STPG_LEARNING: begin
                    if (go_blocking) begin
                        state_next = STPG_BLOCKING;
                        fd_clear   = 1'b1;
                    end else if (fd_expired) begin
                        state_next = STPG_FORWARDING;
                    end
                end
                STPG_FORWARDING: begin
                    if (go_blocking) begin
                        state_next = STPG_BLOCKING;
                        fd_clear   = 1'b1;
                    end
                end
                STPG_DISABLED: begin
                    // Re-enabled port starts over as after boot
                    state_next = STPG_BLOCKING;
                    fd_load    = 1'b1;
                end
                default: begin
                    state_next = STPG_BLOCKING;
                    fd_clear   = 1'b1;
                end
            endcase
        end
        // Blocking with no exchange arms the forward delay once
        if (state_reg == STPG_BLOCKING && state_next == STPG_BLOCKING && port_enable && stp_enable
            && !bpdu_exchange && !ma_running_reg && !superior_bpdu && !fd_expired && !fd_busy) begin
            fd_load = 1'b1;
        end
    end

    // Tracks whether the forward delay is counting in blocking
    assign fd_busy = fd_busy_reg;

    always_comb begin
        fd_busy_next = fd_busy_reg;
        if (fd_clear || fd_expired) begin
            fd_busy_next = 1'b0;
        end
        if (fd_load) begin
            fd_busy_next = 1'b1;
        end
    end

    assign rx_data  = rx_frame_valid && !rx_frame_is_bpdu && !rx_frame_is_mgmt;
    assign cpu_take = (state_reg == STPG_LISTENING) || (state_reg == STPG_LEARNING)
                      || (state_reg == STPG_FORWARDING);

    always_comb begin
        rx_fwd_next    = 1'b0;
        rx_drop_next   = 1'b0;
        fab_tx_next    = 1'b0;
        fab_drop_next  = 1'b0;
        bpdu_cpu_next  = 1'b0;
        bpdu_tx_next   = 1'b0;
        bpdu_cons_next = 1'b0;
        mgmt_cpu_next  = rx_frame_valid && rx_frame_is_mgmt;
        unique case (state_reg)
            STPG_FORWARDING: begin
                rx_fwd_next = rx_data;
                fab_tx_next = fab_frame_valid;
            end
            default: begin
                rx_drop_next  = rx_data;
                fab_drop_next = fab_frame_valid;
            end
        endcase
        if (state_reg != STPG_DISABLED) begin
            bpdu_cpu_next = rx_frame_valid && rx_frame_is_bpdu;
        end
        if (cpu_bpdu_valid && cpu_take) begin
            bpdu_cons_next = (state_reg == STPG_LISTENING);
            bpdu_tx_next   = (state_reg != STPG_LISTENING);
        end
    end

    // Only a processing state takes CPU BPDUs; blocked ones wait
    assign cpu_bpdu_ready = cpu_take;
    assign learn_en = (state_reg == STPG_LEARNING) || (state_reg == STPG_FORWARDING);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg      <= STPG_BLOCKING;
            ma_running_reg <= 1'b0;
            fd_busy_reg    <= 1'b0;
            rx_fwd_reg     <= 1'b0;
            rx_drop_reg    <= 1'b0;
            fab_tx_reg     <= 1'b0;
            fab_drop_reg   <= 1'b0;
            bpdu_cpu_reg   <= 1'b0;
            mgmt_cpu_reg   <= 1'b0;
            bpdu_tx_reg    <= 1'b0;
            bpdu_cons_reg  <= 1'b0;
        end else begin
            state_reg      <= state_next;
            ma_running_reg <= ma_running_next;
            fd_busy_reg    <= fd_busy_next;
            rx_fwd_reg     <= rx_fwd_next;
            rx_drop_reg    <= rx_drop_next;
            fab_tx_reg     <= fab_tx_next;
            fab_drop_reg   <= fab_drop_next;
            bpdu_cpu_reg   <= bpdu_cpu_next;
            mgmt_cpu_reg   <= mgmt_cpu_next;
            bpdu_tx_reg    <= bpdu_tx_next;
            bpdu_cons_reg  <= bpdu_cons_next;
        end
    end

    assign rx_fwd       = rx_fwd_reg;
    assign rx_drop      = rx_drop_reg;
    assign fab_tx       = fab_tx_reg;
    assign fab_drop     = fab_drop_reg;
    assign bpdu_to_cpu  = bpdu_cpu_reg;
    assign mgmt_to_cpu  = mgmt_cpu_reg;
    assign bpdu_tx      = bpdu_tx_reg;
    assign bpdu_consume = bpdu_cons_reg;
    assign port_state   = state_reg;

    property p_listen_to_learn;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == STPG_LISTENING && fd_expired && !go_blocking && port_enable && stp_enable)
        |=> state_reg == STPG_LEARNING;
    endproperty
    a_listen_to_learn: assert property (p_listen_to_learn) else $error("listening did not advance");

    property p_listen_back;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == STPG_LISTENING && go_blocking && port_enable && stp_enable) |=> state_reg == STPG_BLOCKING;
    endproperty
    a_listen_back: assert property (p_listen_back) else $error("listening ignored better port");

    property p_learn_to_fwd;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == STPG_LEARNING && fd_expired && !go_blocking && port_enable && stp_enable)
        |=> state_reg == STPG_FORWARDING;
    endproperty
    a_learn_to_fwd: assert property (p_learn_to_fwd) else $error("learning did not advance");

    property p_no_fwd_unless_fwd;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg != STPG_FORWARDING && rx_frame_valid) |=> !rx_fwd && !fab_tx;
    endproperty
    a_no_fwd_unless_fwd: assert property (p_no_fwd_unless_fwd) else $error("frame forwarded early");

    property p_fwd_passes;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == STPG_FORWARDING && fab_frame_valid) |=> fab_tx;
    endproperty
    a_fwd_passes: assert property (p_fwd_passes) else $error("fabric frame lost");

    property p_block_no_tx;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == STPG_BLOCKING || state_reg == STPG_DISABLED) |=> !bpdu_tx;
    endproperty
    a_block_no_tx: assert property (p_block_no_tx) else $error("BPDU sent while blocked");

    property p_bpdu_cpu;
        @(posedge core_clk) disable iff (!rst_b)
        (rx_frame_valid && rx_frame_is_bpdu) |=> (bpdu_to_cpu == ($past(state_reg) != STPG_DISABLED));
    endproperty
    a_bpdu_cpu: assert property (p_bpdu_cpu) else $error("BPDU steering wrong");

    property p_mgmt;
        @(posedge core_clk) disable iff (!rst_b)
        (rx_frame_valid && rx_frame_is_mgmt) |=> mgmt_to_cpu;
    endproperty
    a_mgmt: assert property (p_mgmt) else $error("management frame lost");

    property p_learn;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == STPG_LEARNING || state_reg == STPG_FORWARDING) |-> learn_en;
    endproperty
    a_learn: assert property (p_learn) else $error("learning off");

endmodule

// *** src/stpg_pkg.sv ***
// Shared constants and types for the port spanning tree state gate
package stpg_pkg;

    typedef enum logic [2:0] {
        STPG_BLOCKING   = 3'b000,
        STPG_LISTENING  = 3'b001,
        STPG_LEARNING   = 3'b010,
        STPG_FORWARDING = 3'b011,
        STPG_DISABLED   = 3'b100
    } stpg_state_type;

    localparam int unsigned STPG_CLK_HZ          = 200_000_000;
    localparam int unsigned STPG_FWD_DELAY_S     = 15;
    localparam int unsigned STPG_MAX_AGE_S       = 20;
    localparam longint unsigned STPG_FWD_DELAY_CYC = longint'(STPG_FWD_DELAY_S) * STPG_CLK_HZ;
    localparam longint unsigned STPG_MAX_AGE_CYC   = longint'(STPG_MAX_AGE_S) * STPG_CLK_HZ;
    localparam int unsigned STPG_TMR_W           = 33;
    localparam logic [32:0] STPG_TMR_ZERO        = 33'h000000000;
    localparam logic [32:0] STPG_TMR_ONE         = 33'h000000001;

endpackage

// *** src/stpg_timer.sv ***
// Down counter that pulses once when a loaded count runs out
`timescale 1ns/1ps
module stpg_timer
    import stpg_pkg::*;
#(
    parameter int unsigned W = STPG_TMR_W
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         load,
    input  wire logic         clear,
    input  wire logic [W-1:0] load_val,
    output logic              expired
);

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         exp_reg;
    logic         exp_next;

    always_comb begin
        cnt_next = cnt_reg;
        exp_next = 1'b0;
        if (clear) begin
            cnt_next = '0;
        end else if (load) begin
            cnt_next = load_val;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - W'(1);
            exp_next = (cnt_reg == W'(1));
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
        end
    end

    assign expired = exp_reg;

endmodule

// *** test/stpg_cpu_model.sv ***
// Switch CPU model that offers BPDUs to the port gate for sending
`timescale 1ns/1ps
module stpg_cpu_model (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic offer,
    input  wire logic abort,
    input  wire logic cpu_bpdu_ready,
    output logic      cpu_bpdu_valid,
    output logic      taken
);
    logic valid_reg;
    logic valid_next;
    logic taken_reg;
    logic taken_next;

    // Offer stays up until taken; only a bench abort withdraws a refused one
    always_comb begin
        valid_next = valid_reg;
        taken_next = 1'b0;
        if (valid_reg && cpu_bpdu_ready) begin
            valid_next = 1'b0;
            taken_next = 1'b1;
        end else if (abort) begin
            valid_next = 1'b0;
        end else if (offer) begin
            valid_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            valid_reg <= 1'b0;
            taken_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
            taken_reg <= taken_next;
        end
    end

    assign cpu_bpdu_valid = valid_reg;
    assign taken          = taken_reg;
endmodule

// *** test/tb.sv ***
// Self-checking bench for the port spanning tree state gate
`timescale 1ns/1ps
module tb;
    import stpg_pkg::*;
    localparam int FWD = 20;
    localparam int MAX = 30;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic stp_enable = 1'b1, port_enable = 1'b1, bpdu_exchange = 1'b0, superior_bpdu = 1'b0;
    logic go_blocking = 1'b0, go_forward = 1'b0, rx_frame_valid = 1'b0, rx_frame_is_bpdu = 1'b0;
    logic rx_frame_is_mgmt = 1'b0, fab_frame_valid = 1'b0, offer = 1'b0, abort = 1'b0;
    logic cpu_bpdu_valid, cpu_bpdu_ready, rx_fwd, rx_drop, fab_tx, fab_drop, learn_en;
    logic bpdu_to_cpu, mgmt_to_cpu, bpdu_tx, bpdu_consume, taken;
    logic [2:0] port_state;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int t0 = 0;

    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    stpg_port_gate #(.FWD_DELAY_CYC(FWD), .MAX_AGE_CYC(MAX)) i_stpg_port_gate (
        .core_clk(core_clk), .rst_b(rst_b), .stp_enable(stp_enable), .port_enable(port_enable),
        .bpdu_exchange(bpdu_exchange), .superior_bpdu(superior_bpdu), .go_blocking(go_blocking),
        .go_forward(go_forward), .rx_frame_valid(rx_frame_valid), .rx_frame_is_bpdu(rx_frame_is_bpdu),
        .rx_frame_is_mgmt(rx_frame_is_mgmt), .fab_frame_valid(fab_frame_valid),
        .cpu_bpdu_valid(cpu_bpdu_valid), .cpu_bpdu_ready(cpu_bpdu_ready), .rx_fwd(rx_fwd),
        .rx_drop(rx_drop), .fab_tx(fab_tx), .fab_drop(fab_drop), .learn_en(learn_en),
        .bpdu_to_cpu(bpdu_to_cpu), .mgmt_to_cpu(mgmt_to_cpu), .bpdu_tx(bpdu_tx),
        .bpdu_consume(bpdu_consume), .port_state(port_state));

    stpg_cpu_model i_stpg_cpu_model (
        .core_clk(core_clk), .rst_b(rst_b), .offer(offer), .abort(abort),
        .cpu_bpdu_ready(cpu_bpdu_ready), .cpu_bpdu_valid(cpu_bpdu_valid), .taken(taken));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Strobe selectors, so one task can pulse any of them
    localparam int P_OFFER = 0;
    localparam int P_ABORT = 1;
    localparam int P_BLOCK = 2;
    localparam int P_FWD   = 3;
    localparam int P_SUP   = 4;

    task automatic set_strobe(input int which, input logic v);
        case (which)
            P_OFFER: offer = v;
            P_ABORT: abort = v;
            P_BLOCK: go_blocking = v;
            P_FWD:   go_forward = v;
            default: superior_bpdu = v;
        endcase
    endtask

    task automatic pulse(input int which);
        @(posedge core_clk); #1 set_strobe(which, 1'b1);
        @(posedge core_clk); #1 set_strobe(which, 1'b0);
    endtask

    // Data and fabric frames together, then BPDU and management frames back to back, outputs one cycle later
    task automatic probe(input logic f, input logic l, input logic b);
        @(posedge core_clk); #1;
        rx_frame_valid = 1'b1;
        fab_frame_valid = 1'b1;
        @(posedge core_clk); #1;
        check("rx_gate", {1'b0, rx_fwd, rx_drop}, {1'b0, f, ~f});
        check("fab_gate", {1'b0, fab_tx, fab_drop}, {1'b0, f, ~f});
        check("learn_en", {2'b0, learn_en}, {2'b0, l});
        fab_frame_valid = 1'b0;
        rx_frame_is_bpdu = 1'b1;
        @(posedge core_clk); #1;
        check("bpdu_to_cpu", {2'b0, bpdu_to_cpu}, {2'b0, b});
        rx_frame_is_bpdu = 1'b0;
        rx_frame_is_mgmt = 1'b1;
        @(posedge core_clk); #1;
        check("mgmt_to_cpu", {2'b0, mgmt_to_cpu}, 3'h1);
        rx_frame_valid = 1'b0;
        rx_frame_is_mgmt = 1'b0;
    endtask

    // CPU offers a BPDU; a refused offer is withdrawn after a bounded wait
    task automatic cpu_send(input logic tk, input logic tx, input logic cs);
        logic got;
        logic gtx;
        logic gcs;
        got = 1'b0;
        gtx = 1'b0;
        gcs = 1'b0;
        pulse(P_OFFER);
        for (int i = 0; i < 6 && !got; i++) begin
            @(posedge core_clk); #1;
            got = taken;
            gtx = gtx | bpdu_tx;
            gcs = gcs | bpdu_consume;
        end
        check("bpdu_taken", {2'b0, got}, {2'b0, tk});
        check("bpdu_tx_cons", {1'b0, gtx, gcs}, {1'b0, tx, cs});
        if (!got) pulse(P_ABORT);
    endtask

    // Wait for a state, judging the elapsed cycles since t0
    task automatic wait_state(input stpg_state_type st, input int lo, input int hi);
        int n;
        n = 0;
        while (port_state !== st && n < hi + 8) begin
            @(posedge core_clk); #1;
            n++;
        end
        check("port_state", port_state, st);
        if (port_state !== st) stop_test();
        check("delay", {2'b0, (cyc - t0 >= lo) && (cyc - t0 <= hi)}, 3'h1);
        t0 = cyc;
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        #1 rst_b = 1'b1;
        t0 = cyc;
        check("reset_state", port_state, STPG_BLOCKING);
        probe(1'b0, 1'b0, 1'b1);
        cpu_send(1'b0, 1'b0, 1'b0);
        wait_state(STPG_LISTENING, FWD, FWD + 4);
        probe(1'b0, 1'b0, 1'b1);
        cpu_send(1'b1, 1'b0, 1'b1);
        t0 = cyc;
        pulse(P_BLOCK);
        wait_state(STPG_BLOCKING, 0, 2);
        wait_state(STPG_LISTENING, FWD, FWD + 4);
        wait_state(STPG_LEARNING, FWD, FWD + 4);
        probe(1'b0, 1'b1, 1'b1);
        cpu_send(1'b1, 1'b1, 1'b0);
        wait_state(STPG_FORWARDING, FWD, FWD + 4);
        probe(1'b1, 1'b1, 1'b1);
        // Exchange in progress, so only the max age or go_forward can release the block
        bpdu_exchange = 1'b1;
        t0 = cyc;
        pulse(P_BLOCK);
        wait_state(STPG_BLOCKING, 0, 2);
        pulse(P_SUP);
        // Refresh lands on the last count, so a missed restart shows as an early release
        repeat (MAX - 2) @(posedge core_clk);
        #1 check("max_age_hold", port_state, STPG_BLOCKING);
        pulse(P_SUP);
        t0 = cyc;
        wait_state(STPG_LISTENING, MAX - 1, MAX + 4);
        port_enable = 1'b0;
        wait_state(STPG_DISABLED, 0, 2);
        probe(1'b0, 1'b0, 1'b0);
        cpu_send(1'b0, 1'b0, 1'b0);
        t0 = cyc;
        port_enable = 1'b1;
        wait_state(STPG_BLOCKING, 0, 2);
        pulse(P_FWD);
        wait_state(STPG_LISTENING, 0, 3);
        stp_enable = 1'b0;
        wait_state(STPG_FORWARDING, 0, 3);
        stop_test();
    end
endmodule
